// ---- bcrf_pkg.sv ----
// Package for the banked CPU register file: widths, field positions and reset values.
// Assumes a single clock domain; used by bcrf_top and bcrf_top_test.
package bcrf_pkg;
   localparam int          NUM_BANKS      = 8;
   localparam int          REGS_PER_BANK  = 16;
   localparam int          BANK_BITS      = 3;
   localparam int          REG_BITS       = 4;
   localparam int          PAIR_BITS      = 3;
   localparam int          EXP_BITS       = 2;
   localparam int          PC_WIDTH       = 20;
   localparam int          PSW_WIDTH      = 16;
   localparam int          PSW_RSS_BIT    = 5;
   localparam int          PSW_BANK_LSB   = 12;
   localparam logic [19:0] PC_RESET       = 20'h0_0000;
   localparam logic [15:0] PSW_RESET      = 16'h0000;
   localparam logic [7:0]  EXP_RESET      = 8'h00;
   localparam logic [3:0]  LEGACY_X_REG   = 4'h4;
   localparam logic [3:0]  LEGACY_A_REG   = 4'h5;
   localparam logic [3:0]  LEGACY_C_REG   = 4'h6;
   localparam logic [3:0]  LEGACY_B_REG   = 4'h7;
   localparam logic [2:0]  PAIR_TWO       = 3'h2;
   localparam logic [2:0]  PAIR_THREE     = 3'h3;
   localparam logic [2:0]  FIRST_ADDR_PAIR = 3'h4;
   // Legacy names: 0 = X, 1 = A, 2 = C, 3 = B, 4 = accumulator pair, 5 = count pair.
   typedef enum logic [2:0] {
      BCRF_LEG_X, BCRF_LEG_A, BCRF_LEG_C, BCRF_LEG_B, BCRF_LEG_AX, BCRF_LEG_BC
   } bcrf_legacy_e;
endpackage : bcrf_pkg

// ---- bcrf_ram_if.sv ----
// Interface carrying the internal RAM window onto the register banks.
// Assumes all signals are synchronous to the core clock.
`timescale 1ns/1ps
interface bcrf_ram_if;
   logic       wr;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport store (input wr, input addr, input wdata, output rdata);
   modport user  (output wr, output addr, output wdata, input rdata);
endinterface : bcrf_ram_if

// ---- bcrf_ram_port.sv ----
// Register bank storage: 8 banks x 16 bytes, one byte write port for the CPU,
// one pair write, and a RAM-side byte port. Assumes one clock.
`timescale 1ns/1ps
module bcrf_ram_port #(
   parameter int DEPTH = 128
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // CPU side
   input  wire logic       cpu_wr,
   input  wire logic [6:0] cpu_addr,
   input  wire logic [7:0] cpu_wdata,
   input  wire logic       cpu_pair_wr,
   input  wire logic [6:0] cpu_pair_addr,
   input  wire logic [15:0] cpu_pair_wdata,
   output logic [7:0]      cpu_rdata,
   output logic [15:0]     cpu_pair_rdata,
   input  wire logic [6:0] cpu_raddr,
   input  wire logic [6:0] cpu_pair_raddr,
   // Address pair read, separate so the 24-bit address never depends on the CPU pair select
   input  wire logic [6:0] addr_pair_raddr,
   output logic [15:0]     addr_pair_rdata,
   // Internal RAM window
   bcrf_ram_if.store       ram
);
   if (DEPTH != 128) begin : g_bad_depth
      $error("bcrf_ram_port supports only 128 bytes");
   end

   logic [7:0] mem [DEPTH];

   // The RAM side writes last, so it wins a same-cycle collision with the CPU.
   always_ff @(posedge clock) begin
      if (cpu_wr) mem[cpu_addr] <= cpu_wdata;
      if (cpu_pair_wr) begin
         mem[{cpu_pair_addr[6:1], 1'b0}] <= cpu_pair_wdata[7:0];
         mem[{cpu_pair_addr[6:1], 1'b1}] <= cpu_pair_wdata[15:8];
      end
      if (ram.wr) mem[ram.addr] <= ram.wdata;
   end

   assign cpu_rdata      = mem[cpu_raddr];
   assign cpu_pair_rdata = {mem[{cpu_pair_raddr[6:1], 1'b1}], mem[{cpu_pair_raddr[6:1], 1'b0}]};
   assign ram.rdata      = mem[ram.addr];
   assign addr_pair_rdata = {mem[{addr_pair_raddr[6:1], 1'b1}],
                             mem[{addr_pair_raddr[6:1], 1'b0}]};
endmodule : bcrf_ram_port

// ---- bcrf_top.sv ----
// What this block does
// (RULE1) Eight register banks; exactly one is the active working set.
// (RULE2) Each bank holds sixteen individually addressed 8-bit registers.
// (RULE3) Two byte registers act together as one 16-bit pair.
// (RULE4) Four pairs join an 8-bit expansion register into a 24-bit address.
// (RULE5) Active bank set by software or by context switching.
// (RULE6) Bank storage lives in internal RAM; expansion registers do not.
// (RULE7) With the select flag set, R4-R7 and two pairs answer legacy names.
// (RULE8) Software keeps the register-set-select flag at zero except legacy code.
// (RULE9) Program counter is 20 bits and advances as instructions execute.
// (RULE10) Status word holds CPU flags, updated by instruction execution.
// (RULE11) Active bank is a 3-bit field, values 0 to 7.
// Top of the banked CPU register file: banks, pairs, expansion registers,
// program counter and status word. Assumes the core drives all controls synchronously.
`timescale 1ns/1ps
module bcrf_top (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Byte register access
   input  wire logic        reg_wr,
   input  wire logic [3:0]  reg_sel,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   // Pair register access
   input  wire logic        pair_wr,
   input  wire logic [2:0]  pair_sel,
   input  wire logic [15:0] pair_wdata,
   output logic [15:0]      pair_rdata,
   // Legacy name access
   input  wire logic        legacy_wr,
   input  wire logic [2:0]  legacy_sel,
   input  wire logic [15:0] legacy_wdata,
   output logic [15:0]      legacy_rdata,
   output logic             legacy_valid,
   // Address expansion
   input  wire logic        exp_wr,
   input  wire logic [1:0]  exp_sel,
   input  wire logic [7:0]  exp_wdata,
   input  wire logic [1:0]  addr_sel,
   output logic [23:0]      addr_out,
   // Bank selection
   input  wire logic        bank_set,
   input  wire logic [2:0]  bank_wdata,
   input  wire logic        ctx_switch,
   input  wire logic [2:0]  ctx_bank,
   output logic [2:0]       active_bank,
   // Program counter
   input  wire logic        pc_advance,
   input  wire logic [2:0]  pc_step,
   input  wire logic        pc_load,
   input  wire logic [19:0] pc_wdata,
   output logic [19:0]      program_counter,
   // Status word
   input  wire logic        psw_wr,
   input  wire logic [15:0] psw_wdata,
   input  wire logic        flags_wr,
   input  wire logic [7:0]  flags_wdata,
   output logic [15:0]      program_status_word,
   output logic             register_set_select_flag,
   // Internal RAM window
   input  wire logic        ram_wr,
   input  wire logic [6:0]  ram_addr,
   input  wire logic [7:0]  ram_wdata,
   output logic [7:0]       ram_rdata
);
   logic [7:0]  exp_reg [4];
   logic [19:0] next_pc;
   logic [15:0] next_psw;
   logic [7:0]  stor_rdata;
   logic [15:0] stor_pair_rdata;

   bcrf_ram_if ram_bus ();

   function automatic logic [6:0] bank_addr(input logic [2:0] bank, input logic [3:0] r);
      return {bank, r};
   endfunction : bank_addr

   // The bank field of the status word is the single source of the active bank.
   assign active_bank              = program_status_word[bcrf_pkg::PSW_BANK_LSB +: 3]; // see RULE11
   assign register_set_select_flag = program_status_word[bcrf_pkg::PSW_RSS_BIT];

   // Legacy names map onto fixed registers of the active bank.
   logic [3:0] legacy_reg;
   logic       legacy_is_pair;
   logic [2:0] legacy_pair;
   assign legacy_is_pair = (legacy_sel == 3'h4) || (legacy_sel == 3'h5);
   assign legacy_pair    = (legacy_sel == 3'h4) ? bcrf_pkg::PAIR_TWO : bcrf_pkg::PAIR_THREE;
   assign legacy_reg     = (legacy_sel == 3'h0) ? bcrf_pkg::LEGACY_X_REG :
                           (legacy_sel == 3'h1) ? bcrf_pkg::LEGACY_A_REG :
                           (legacy_sel == 3'h2) ? bcrf_pkg::LEGACY_C_REG :
                                                  bcrf_pkg::LEGACY_B_REG;
   logic legacy_ok;
   assign legacy_ok    = register_set_select_flag && (legacy_sel <= 3'h5); // see RULE7
   assign legacy_valid = legacy_ok;

   // Byte and pair write ports merge the plain and legacy paths.
   logic        byte_wr;
   logic [6:0]  byte_waddr;
   logic [7:0]  byte_wdata;
   logic        pw;
   logic [6:0]  pw_addr;
   logic [15:0] pw_data;
   assign byte_wr    = reg_wr || (legacy_wr && legacy_ok && !legacy_is_pair);
   assign byte_waddr = reg_wr ? bank_addr(active_bank, reg_sel) : bank_addr(active_bank, legacy_reg);
   assign byte_wdata = reg_wr ? reg_wdata : legacy_wdata[7:0];
   assign pw         = pair_wr || (legacy_wr && legacy_ok && legacy_is_pair); // see RULE3
   assign pw_addr    = pair_wr ? bank_addr(active_bank, {pair_sel, 1'b0})
                               : bank_addr(active_bank, {legacy_pair, 1'b0});
   assign pw_data    = pair_wr ? pair_wdata : legacy_wdata;

   logic [6:0] byte_raddr;
   logic [6:0] pair_raddr;
   assign byte_raddr = legacy_is_pair ? bank_addr(active_bank, reg_sel)
                     : (legacy_ok ? bank_addr(active_bank, legacy_reg)
                                  : bank_addr(active_bank, reg_sel));
   assign pair_raddr = bank_addr(active_bank, {pair_sel, 1'b0});

   // Pairs four to seven of the active bank feed the 24-bit address.
   logic [2:0]  addr_pair_idx;
   logic [15:0] addr_pair;
   assign addr_pair_idx = 3'(bcrf_pkg::FIRST_ADDR_PAIR + {1'b0, addr_sel});

   assign ram_bus.wr    = ram_wr;
   assign ram_bus.addr  = ram_addr;
   assign ram_bus.wdata = ram_wdata;
   assign ram_rdata     = ram_bus.rdata; // see RULE6

   // Banks sit in the RAM-shared store, selected by the active bank.
   bcrf_ram_port #(.DEPTH(bcrf_pkg::NUM_BANKS * bcrf_pkg::REGS_PER_BANK)) u_store ( // see RULE1
      .clock          (clock),
      .rst            (rst),
      .cpu_wr         (byte_wr), // see RULE2
      .cpu_addr       (byte_waddr),
      .cpu_wdata      (byte_wdata),
      .cpu_pair_wr    (pw),
      .cpu_pair_addr  (pw_addr),
      .cpu_pair_wdata (pw_data),
      .cpu_rdata      (stor_rdata),
      .cpu_pair_rdata (stor_pair_rdata),
      .cpu_raddr      (byte_raddr),
      .cpu_pair_raddr (legacy_ok && legacy_is_pair ? bank_addr(active_bank, {legacy_pair, 1'b0})
                                                   : pair_raddr),
      .addr_pair_raddr (bank_addr(active_bank, {addr_pair_idx, 1'b0})),
      .addr_pair_rdata (addr_pair),
      .ram            (ram_bus.store)
   );

   assign reg_rdata    = stor_rdata;
   assign pair_rdata   = stor_pair_rdata;
   assign legacy_rdata = !legacy_ok ? 16'h0000 :
                         legacy_is_pair ? stor_pair_rdata : {8'h00, stor_rdata};

   // Expansion registers are flops outside the RAM store.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) exp_reg[i] <= bcrf_pkg::EXP_RESET;
      end else if (exp_wr) begin
         exp_reg[exp_sel] <= exp_wdata; // see RULE6
      end
   end

   // A dedicated read port keeps the address valid while the CPU reads any other pair.
   assign addr_out = {exp_reg[addr_sel], addr_pair}; // see RULE4

   // Program counter: a load wins over the automatic advance.
   assign next_pc = pc_load ? pc_wdata :
                    pc_advance ? program_counter + {17'h0_0000, pc_step} : program_counter;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) program_counter <= bcrf_pkg::PC_RESET;
      else     program_counter <= next_pc; // see RULE9
   end

   // Status word: context switch beats a software bank set, which beats plain writes.
   always_comb begin
      next_psw = program_status_word;
      if (psw_wr)   next_psw = psw_wdata; // see RULE10
      if (flags_wr) next_psw[7:0] = flags_wdata; // see RULE10
      if (bank_set) next_psw[bcrf_pkg::PSW_BANK_LSB +: 3] = bank_wdata; // see RULE5
      if (ctx_switch) next_psw[bcrf_pkg::PSW_BANK_LSB +: 3] = ctx_bank; // see RULE5
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) program_status_word <= bcrf_pkg::PSW_RESET;
      else     program_status_word <= next_psw;
   end
endmodule : bcrf_top

// ---- bcrf_top_asserts.sv ----
// Checker for the register file: bank choice, status word, counter and byte path.
// Assumes it is bound to bcrf_top and sees only that module's ports.
`timescale 1ns/1ps
module bcrf_top_asserts (
   // Clock and reset
   input wire logic        clock, rst,
   // Byte path
   input wire logic        reg_wr, pair_wr, ram_wr, legacy_valid,
   input wire logic [3:0]  reg_sel,
   input wire logic [7:0]  reg_wdata, reg_rdata,
   input wire logic [15:0] legacy_rdata, program_status_word,
   // Bank and counter control
   input wire logic        bank_set, ctx_switch, register_set_select_flag, pc_advance, pc_load,
   input wire logic [2:0]  bank_wdata, ctx_bank, active_bank, pc_step,
   input wire logic [19:0] pc_wdata, program_counter
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // The legacy override shares the read port, so bytes are compared only with the flag clear.
   sequence s_byte_wr;
      reg_wr && !pair_wr && !ram_wr && !register_set_select_flag;
   endsequence
   sequence s_same_place;
      $stable(reg_sel) && $stable(active_bank) && !register_set_select_flag;
   endsequence
   a_ctx_bank: assert property (ctx_switch |=> active_bank == $past(ctx_bank))
      else $error("context bank not taken");
   a_sw_bank: assert property (bank_set && !ctx_switch |=> active_bank == $past(bank_wdata))
      else $error("software bank not taken");
   a_bank_field: assert property (active_bank == program_status_word[14:12])
      else $error("bank field mismatch");
   a_legacy_off: assert property (!register_set_select_flag |-> !legacy_valid)
      else $error("legacy answer with flag clear");
   a_legacy_zero: assert property (!register_set_select_flag |-> legacy_rdata == 16'h0000)
      else $error("legacy data with flag clear");
   a_pc_load: assert property (pc_load |=> program_counter == $past(pc_wdata))
      else $error("counter load lost");
   a_pc_step: assert property (pc_advance && !pc_load |=>
      program_counter == 20'($past(program_counter) + $past(pc_step))) else $error("bad step");
   a_pc_hold: assert property (!pc_advance && !pc_load |=> $stable(program_counter))
      else $error("counter moved");
   a_byte_write: assert property (s_byte_wr ##1 s_same_place |-> reg_rdata == $past(reg_wdata))
      else $error("byte write lost");
endmodule : bcrf_top_asserts
bind bcrf_top bcrf_top_asserts bcrf_top_asserts_i (.*);

// ---- bcrf_ram_agent.sv ----
// Model of internal RAM reaching the register banks through the RAM window.
// Assumes the core clock; the testbench calls its tasks.
`timescale 1ns/1ps
module bcrf_ram_agent (
   // Clock
   input wire logic        clock,
   // RAM window
   output logic            ram_wr,
   output logic [6:0]      ram_addr,
   output logic [7:0]      ram_wdata,
   input wire logic [7:0]  ram_rdata
);
   initial {ram_wr, ram_addr, ram_wdata} = '0;
   task poke(input logic [6:0] a, input logic [7:0] v);
      @(posedge clock);
      {ram_wr, ram_addr, ram_wdata} <= {1'b1, a, v};
      @(posedge clock);
      // Idle data is inverted so that a stale byte never looks fresh.
      {ram_wr, ram_wdata} <= {1'b0, ~v};
   endtask : poke
   task peek(input logic [6:0] a, output logic [7:0] v);
      @(posedge clock);
      ram_addr <= a;
      #1 v = ram_rdata;
   endtask : peek
endmodule : bcrf_ram_agent

// ---- bcrf_top_test.sv ----
// Self-checking bench for the register file: banks, pairs, expansion, legacy, counter.
// Assumes the RAM agent and the bound checker are compiled alongside.
`timescale 1ns/1ps
module bcrf_top_test;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr, pair_wr, legacy_wr, exp_wr, bank_set, ctx_switch, pc_advance, pc_load;
   logic        psw_wr, flags_wr, ram_wr, legacy_valid, register_set_select_flag;
   logic [1:0]  exp_sel, addr_sel;
   logic [2:0]  pair_sel, legacy_sel, bank_wdata, ctx_bank, pc_step, active_bank;
   logic [3:0]  reg_sel;
   logic [6:0]  ram_addr;
   logic [7:0]  reg_wdata, exp_wdata, flags_wdata, ram_wdata, reg_rdata, ram_rdata, d;
   logic [15:0] pair_wdata, legacy_wdata, psw_wdata, pair_rdata, legacy_rdata, program_status_word;
   logic [19:0] pc_wdata, program_counter;
   logic [23:0] addr_out;
   int          err_total = 0;
   int          tests_run = 0;
   bcrf_top       bcrf_top_i (.*);
   bcrf_ram_agent bcrf_ram_agent_i (.*);
   always #4 clock = ~clock;
   task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task set_bank(input logic [2:0] b);
      @(posedge clock);
      {bank_set, bank_wdata} <= {1'b1, b};
      @(posedge clock);
      bank_set <= 1'b0;
   endtask : set_bank
   task wr_byte(input logic [3:0] s, input logic [7:0] v);
      @(posedge clock);
      {reg_wr, reg_sel, reg_wdata} <= {1'b1, s, v};
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr_byte
   task t_banks();
      for (int b = 0; b < 8; b++) begin
         set_bank(3'(b));
         wr_byte(4'h3, 8'(8'hA0 + b));
         wr_byte(4'hF, 8'(8'h50 + b));
      end
      for (int b = 0; b < 8; b++) begin
         set_bank(3'(b));
         reg_sel <= 4'h3;
         #1 chk("active_bank", 24'(b), 24'(active_bank));
         chk("reg_rdata", 24'(8'hA0 + b), 24'(reg_rdata));
         bcrf_ram_agent_i.peek({3'(b), 4'hF}, d);
         chk("ram_rdata", 24'(8'h50 + b), 24'(d));
      end
      bcrf_ram_agent_i.poke(7'h73, 8'hC3);
      #1 chk("ram to reg", 24'h00_00C3, 24'(reg_rdata));
   endtask : t_banks
   task t_pair_exp();
      @(posedge clock);
      {pair_wr, pair_sel, pair_wdata, addr_sel} <= {1'b1, 3'h5, 16'hBEEF, 2'h1};
      {exp_wr, exp_sel, exp_wdata} <= {1'b1, 2'h1, 8'h5A};
      @(posedge clock);
      {pair_wr, exp_wr, reg_sel} <= {2'b00, 4'hB};
      #1 chk("high byte", 24'h00_00BE, 24'(reg_rdata));
      chk("addr_out", 24'h5A_BEEF, addr_out);
      wr_byte(4'hA, 8'h12);
      #1 chk("pair_rdata", 24'h00_BE12, 24'(pair_rdata));
   endtask : t_pair_exp
   task t_psw();
      @(posedge clock);
      {flags_wr, flags_wdata, pair_sel} <= {1'b1, 8'h9C, 3'h0};
      #1 chk("addr_out other pair", 24'h5A_BE12, addr_out);
      @(posedge clock);
      {flags_wr, ctx_switch, ctx_bank, bank_set, bank_wdata} <= {2'b01, 3'h2, 1'b1, 3'h6};
      #1 chk("status word", 24'h00_709C, 24'(program_status_word));
      chk("legacy_valid", 24'h00_0000, 24'(legacy_valid));
      @(posedge clock);
      {ctx_switch, bank_set, psw_wr, psw_wdata} <= {3'b001, 16'h4020};
      #1 chk("ctx bank", 24'h00_0002, 24'(active_bank));
      @(posedge clock);
      psw_wr <= 1'b0;
      wr_byte(4'h4, 8'h3C);
      legacy_sel <= 3'h0;
      #1 chk("legacy_rdata", 24'h00_003C, 24'(legacy_rdata));
      @(posedge clock);
      {psw_wr, psw_wdata} <= {1'b1, 16'h0000};
      @(posedge clock);
      {psw_wr, pc_load, pc_wdata} <= {2'b01, 20'hF_FFFE};
      @(posedge clock);
      {pc_load, pc_advance, pc_step} <= {2'b01, 3'h3};
      #1 chk("pc load", 24'h0F_FFFE, 24'(program_counter));
      @(posedge clock);
      pc_advance <= 1'b0;
      #1 chk("pc step", 24'h00_0001, 24'(program_counter));
   endtask : t_psw
   task t_legacy();
      @(posedge clock);
      {pair_wr, pair_sel, pair_wdata} <= {1'b1, 3'h2, 16'h1111};
      legacy_sel <= 3'h4;
      @(posedge clock);
      {pair_wr, legacy_wr, legacy_wdata} <= {2'b01, 16'h2222};
      #1 chk("legacy off", 24'h00_0000, 24'({legacy_valid, legacy_rdata}));
      @(posedge clock);
      {legacy_wr, psw_wr, psw_wdata} <= {2'b01, 16'h0020};
      #1 chk("refused pair", 24'h00_1111, 24'(pair_rdata));
      @(posedge clock);
      {psw_wr, legacy_wr, legacy_wdata} <= {2'b01, 16'hA55A};
      #1 chk("select flag", 24'h00_0001, 24'(register_set_select_flag));
      chk("legacy pair", 24'h00_1111, 24'(legacy_rdata));
      @(posedge clock);
      {legacy_wr, psw_wr, psw_wdata} <= {2'b01, 16'h0000};
      #1 chk("accum pair", 24'h00_A55A, 24'(pair_rdata));
      @(posedge clock);
      psw_wr <= 1'b0;
   endtask : t_legacy
   initial begin
      {reg_wr, pair_wr, legacy_wr, exp_wr, bank_set, ctx_switch, pc_advance, pc_load} = '0;
      {psw_wr, flags_wr, reg_sel, pair_sel, legacy_sel, bank_wdata, ctx_bank, pc_step} = '0;
      {exp_sel, addr_sel, reg_wdata, exp_wdata, flags_wdata, pc_wdata} = '0;
      {pair_wdata, legacy_wdata, psw_wdata} = '0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      #1 chk("reset pc", 24'(bcrf_pkg::PC_RESET), 24'(program_counter));
      t_banks();
      t_pair_exp();
      t_psw();
      t_legacy();
      report_and_stop();
   end
   // Whole run needs under two thousand cycles.
   initial begin
      #40000;
      err_total++;
      report_and_stop();
   end
endmodule : bcrf_top_test
